/* File: common/pcl_pkg.sv */
// constants of the pll control latch logic
package pcl_pkg;
    localparam int unsigned PCL_WORD_W = 24;
    // latch select codes in the two lowest bits
    localparam logic [1:0] PCL_SEL_REF = 2'h0;
    localparam logic [1:0] PCL_SEL_FB = 2'h1;
    localparam logic [1:0] PCL_SEL_FUNC = 2'h2;
    localparam logic [1:0] PCL_SEL_INIT = 2'h3;
    // function and initialization latch fields
    localparam int unsigned PCL_CRST_BIT = 2;
    localparam int unsigned PCL_PD1_BIT = 3;
    localparam int unsigned PCL_MUX_LSB = 4;
    localparam int unsigned PCL_POL_BIT = 7;
    localparam int unsigned PCL_TRI_BIT = 8;
    localparam int unsigned PCL_FLEN_BIT = 9;
    localparam int unsigned PCL_FLMODE_BIT = 10;
    localparam int unsigned PCL_TC_LSB = 11;
    localparam int unsigned PCL_CUR1_LSB = 15;
    localparam int unsigned PCL_CUR2_LSB = 18;
    localparam int unsigned PCL_PD2_BIT = 21;
    // gain bit position inside the feedback counter word
    localparam int unsigned PCL_GAIN_BIT = 21;
    localparam logic [PCL_WORD_W-1:0] PCL_FUNC_RESET = 24'h000000;
    // fastlock timeout in comparison cycles: tc * step + base
    localparam int unsigned PCL_TO_W = 6;
    localparam logic [PCL_TO_W-1:0] PCL_TO_STEP = 6'h04;
    localparam logic [PCL_TO_W-1:0] PCL_TO_BASE = 6'h03;
    localparam logic [PCL_TO_W-1:0] PCL_TO_LAST = 6'h01;
    // pin synchroniser lanes
    localparam int unsigned PCL_PINS = 4;
    localparam int unsigned PCL_PIN_SCLK = 0;
    localparam int unsigned PCL_PIN_DATA = 1;
    localparam int unsigned PCL_PIN_LE = 2;
    localparam int unsigned PCL_PIN_CE = 3;
endpackage

/* File: logic/pcl_serial_rx.sv */
// pin synchronisers and 24-bit serial input register
`timescale 1ns/1ps
module pcl_serial_rx (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic serial_clock,
    input wire logic serial_in_line,
    input wire logic latch_strobe,
    input wire logic chip_enable,
    output logic [pcl_pkg::PCL_WORD_W-1:0] word_out,
    output logic word_strobe,
    output logic chip_enable_level
);
    import pcl_pkg::*;

    logic [PCL_PINS-1:0] pin_in;
    logic [PCL_PINS-1:0] s1_reg;
    logic [PCL_PINS-1:0] s2_reg;
    logic [PCL_PINS-1:0] s3_reg;
    logic [PCL_PINS-1:0] filt_reg;
    logic [PCL_PINS-1:0] rise;
    logic [PCL_WORD_W-1:0] shift_reg;
    logic [PCL_WORD_W-1:0] shift_next;

    assign pin_in = {chip_enable, latch_strobe, serial_in_line, serial_clock};

    genvar i;
    generate
        for (i = 0; i < PCL_PINS; i++) begin : g_pin
            // a level counts only once stages two and three agree
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    s1_reg[i] <= 1'b0;
                    s2_reg[i] <= 1'b0;
                    s3_reg[i] <= 1'b0;
                    filt_reg[i] <= 1'b0;
                end else begin
                    s1_reg[i] <= pin_in[i];
                    s2_reg[i] <= s1_reg[i];
                    s3_reg[i] <= s2_reg[i];
                    if (s2_reg[i] == s3_reg[i]) begin
                        filt_reg[i] <= s3_reg[i];
                    end
                end
            end
            assign rise[i] = (s2_reg[i] == s3_reg[i]) && s3_reg[i] && !filt_reg[i];
        end
    endgenerate

    // data settles long before the clock edge, so the filtered level is safe
    assign shift_next = {shift_reg[PCL_WORD_W-2:0], filt_reg[PCL_PIN_DATA]};

    // the input register never looks at power-down state
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            shift_reg <= '0;
            word_out <= '0;
            word_strobe <= 1'b0;
        end else begin
            if (rise[PCL_PIN_SCLK]) begin
                shift_reg <= shift_next;
            end
            word_strobe <= rise[PCL_PIN_LE];
            if (rise[PCL_PIN_LE]) begin
                word_out <= shift_reg;
            end
        end
    end

    assign chip_enable_level = filt_reg[PCL_PIN_CE];
endmodule

/* File: logic/pcl_fastlock_timer.sv */
// fastlock timeout counter clocked by comparison events
`timescale 1ns/1ps
module pcl_fastlock_timer (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic enable,
    input wire logic load,
    input wire logic force_load,
    input wire logic tick,
    input wire logic [3:0] timeout_field,
    output logic expire
);
    import pcl_pkg::*;

    logic [PCL_TO_W-1:0] count_reg;
    logic run_reg;
    logic [PCL_TO_W-1:0] load_value;
    logic last_tick;

    assign load_value = PCL_TO_W'({2'h0, timeout_field} * PCL_TO_STEP + PCL_TO_BASE);
    assign last_tick = run_reg && tick && (count_reg == PCL_TO_LAST);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= '0;
            run_reg <= 1'b0;
            expire <= 1'b0;
        end else begin
            expire <= last_tick && enable && !force_load;
            if (force_load || !enable) begin
                run_reg <= 1'b0;
                count_reg <= load_value;
            end else if (load) begin
                run_reg <= 1'b1;
                count_reg <= load_value;
            end else if (run_reg && tick) begin
                count_reg <= count_reg - PCL_TO_W'(1);
                run_reg <= !last_tick;
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    timer_mode_gate_a: assert property (!enable |=> !expire)
        else $error("timeout expired while timer disabled");
    timer_load_a: assert property (load && enable && !force_load |=> count_reg == $past(load_value))
        else $error("timer not loaded from field");
endmodule

/* File: logic/pcl_latch_ctrl.sv */
// control latches, power-down, fastlock and reset pulses of the pll
`timescale 1ns/1ps
// Function
// - code one-zero loads the function latch
// - counter reset bit holds both counters
// - counters leave reset together, aligned
// - chip enable low powers down immediately
// - pd1 with pd2 zero: immediate power-down
// - pd1 with pd2 one: waits pump event
// - power-down holds counters, tri-states, disables buffer
// - input register works during power-down
// - fastlock only when enable bit set
// - mode bit picks fastlock mode
// - gain bit selects secondary pump current
// - mode two timeout clears gain bit
// - timeout counter runs only in mode two
// - two three-bit pump current fields
// - three-state bit floats pump output
// - init word loads latch and pulses reset
// - init pulse triggers armed synchronous power-down
// - first feedback load repeats reset pulse
// - counter reset never starts synchronous power-down
// - 24 serial bits, strobe rise latches
module pcl_latch_ctrl (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic serial_clock,
    input wire logic serial_in_line,
    input wire logic latch_strobe,
    input wire logic chip_enable,
    input wire logic pump_event,
    output logic [pcl_pkg::PCL_WORD_W-1:0] counter_word,
    output logic ref_word_load,
    output logic fb_word_load,
    output logic counters_hold,
    output logic timeout_hold,
    output logic pump_output_en,
    output logic [2:0] pump_current,
    output logic pump_gain_bit,
    output logic fastlock_active,
    output logic detector_polarity_bit,
    output logic [2:0] outmux_select,
    output logic detect_reset,
    output logic ref_buffer_enable,
    output logic powered_down
);
    import pcl_pkg::*;

    logic [PCL_WORD_W-1:0] rx_word;
    logic rx_strobe;
    logic ce_level;
    logic [PCL_WORD_W-1:0] func_reg;
    logic [PCL_WORD_W-1:0] func_next;
    logic init_arm_reg;
    logic init_pulse_reg;
    logic sync_pd_reg;
    logic gain_reg;
    logic gain_next;
    logic timer_expire;

    pcl_serial_rx u_rx (
        .clk(clk),
        .reset_n(reset_n),
        .serial_clock(serial_clock),
        .serial_in_line(serial_in_line),
        .latch_strobe(latch_strobe),
        .chip_enable(chip_enable),
        .word_out(rx_word),
        .word_strobe(rx_strobe),
        .chip_enable_level(ce_level)
    );

    // word decode
    wire [1:0] sel = rx_word[1:0];
    wire ref_load = rx_strobe && (sel == PCL_SEL_REF);
    wire fb_load = rx_strobe && (sel == PCL_SEL_FB);
    wire func_load = rx_strobe && (sel == PCL_SEL_FUNC);
    wire init_load = rx_strobe && (sel == PCL_SEL_INIT);

    // latch fields
    wire counter_reset_bit = func_reg[PCL_CRST_BIT];
    wire powerdown_request_bit = func_reg[PCL_PD1_BIT];
    wire powerdown_sync_select_bit = func_reg[PCL_PD2_BIT];
    wire pump_tri_bit = func_reg[PCL_TRI_BIT];
    wire fastlock_enable_bit = func_reg[PCL_FLEN_BIT];
    wire fastlock_mode_bit = func_reg[PCL_FLMODE_BIT];
    wire [3:0] fastlock_timeout_field = func_reg[PCL_TC_LSB +: 4];
    wire [2:0] primary_current_field = func_reg[PCL_CUR1_LSB +: 3];
    wire [2:0] secondary_current_field = func_reg[PCL_CUR2_LSB +: 3];

    // init and function words share one latch layout
    assign func_next = (func_load || init_load) ? rx_word : func_reg;

    // power-down sources
    wire pin_pd = !ce_level;
    wire async_pd = powerdown_request_bit && !powerdown_sync_select_bit;
    wire sync_armed = powerdown_request_bit && powerdown_sync_select_bit;
    // counter reset is deliberately absent from the trigger
    wire sync_trigger = sync_armed && ce_level && (pump_event || init_pulse_reg);
    wire any_pd = pin_pd || async_pd || sync_pd_reg;

    // fastlock
    wire fl_mode2 = fastlock_enable_bit && fastlock_mode_bit;
    wire gain_write = fb_load;
    wire gain_set = fb_load && rx_word[PCL_GAIN_BIT];
    // a fresh write of one beats a timeout in the same cycle
    assign gain_next = gain_write ? rx_word[PCL_GAIN_BIT] :
        ((timer_expire && fl_mode2) ? 1'b0 : gain_reg);

    wire hold_all = any_pd || counter_reset_bit || init_pulse_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            func_reg <= PCL_FUNC_RESET;
        end else begin
            func_reg <= func_next;
        end
    end

    // reset pulse on init word, repeated once by the next feedback load
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            init_arm_reg <= 1'b0;
            init_pulse_reg <= 1'b0;
        end else begin
            init_pulse_reg <= init_load || (fb_load && init_arm_reg);
            if (init_load) begin
                init_arm_reg <= 1'b1;
            end else if (fb_load) begin
                init_arm_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_pd_reg <= 1'b0;
        end else if (!sync_armed) begin
            sync_pd_reg <= 1'b0;
        end else if (sync_trigger) begin
            sync_pd_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gain_reg <= 1'b0;
        end else begin
            gain_reg <= gain_next;
        end
    end

    pcl_fastlock_timer u_timer (
        .clk(clk),
        .reset_n(reset_n),
        .enable(fl_mode2),
        .load(gain_set),
        .force_load(any_pd || init_pulse_reg),
        .tick(pump_event),
        .timeout_field(fastlock_timeout_field),
        .expire(timer_expire)
    );

    // data outputs
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            counter_word <= '0;
            ref_word_load <= 1'b0;
            fb_word_load <= 1'b0;
        end else begin
            ref_word_load <= ref_load;
            fb_word_load <= fb_load;
            if (ref_load || fb_load) begin
                counter_word <= rx_word;
            end
        end
    end

    // one shared hold releases both counters on the same edge
    assign counters_hold = hold_all;
    assign timeout_hold = any_pd || init_pulse_reg;
    assign pump_output_en = !(hold_all || pump_tri_bit);
    assign fastlock_active = fastlock_enable_bit && gain_reg;
    assign pump_current = fastlock_active ? secondary_current_field :
        primary_current_field;
    assign pump_gain_bit = gain_reg;
    assign detector_polarity_bit = func_reg[PCL_POL_BIT];
    assign outmux_select = func_reg[PCL_MUX_LSB +: 3];
    assign detect_reset = any_pd;
    // the init pulse leaves the buffer alone to keep phase alignment
    assign ref_buffer_enable = !any_pd;
    assign powered_down = any_pd;

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    func_latch_load_a: assert property (func_load |=> func_reg == $past(rx_word))
        else $error("function word not latched");
    counter_reset_hold_a: assert property (counter_reset_bit |-> counters_hold && !pump_output_en)
        else $error("counter reset did not hold counters");
    pin_powerdown_a: assert property (!ce_level |-> powered_down && !ref_buffer_enable)
        else $error("chip enable low did not power down");
    async_powerdown_a: assert property (func_load && rx_word[PCL_PD1_BIT] &&
        !rx_word[PCL_PD2_BIT] |=> powered_down)
        else $error("asynchronous power-down late");
    sync_wait_event_a: assert property (sync_armed && !sync_pd_reg && !pump_event
        && !init_pulse_reg |=> !sync_pd_reg)
        else $error("synchronous power-down without event");
    init_pulse_a: assert property (init_load |=> init_pulse_reg && counters_hold
        && timeout_hold && !pump_output_en)
        else $error("init word gave no reset pulse");
    fb_repeat_once_a: assert property (fb_load && init_arm_reg |=> init_pulse_reg)
        else $error("first feedback load did not repeat pulse");
    fb_no_repeat_a: assert property (fb_load && !init_arm_reg && !init_load
        |=> !init_pulse_reg)
        else $error("later feedback load repeated reset pulse");
    init_buffer_kept_a: assert property (init_pulse_reg && !any_pd |-> ref_buffer_enable)
        else $error("init pulse disabled reference buffer");
    pd_hold_all_a: assert property (powered_down |-> counters_hold && timeout_hold
        && !pump_output_en && detect_reset)
        else $error("power-down did not hold counters and pump");
    mode1_keep_gain_a: assert property (fastlock_enable_bit && !fastlock_mode_bit
        && gain_reg && !fb_load |=> gain_reg)
        else $error("mode one left fastlock by itself");
    crst_no_sync_pd_a: assert property (!sync_pd_reg && !pump_event && !init_pulse_reg
        |=> !sync_pd_reg)
        else $error("synchronous power-down without its trigger");
    tri_state_a: assert property (pump_tri_bit |-> !pump_output_en)
        else $error("pump driven while three-state set");
    fastlock_current_a: assert property (fastlock_active |-> pump_current ==
        secondary_current_field)
        else $error("fastlock did not pick secondary current");
    mode2_clear_a: assert property (timer_expire && fl_mode2 && !fb_load |=> !gain_reg)
        else $error("timeout did not clear gain bit");
endmodule

/* File: testbench/pcl_host_model.sv */
// host side serial writer for the pll control latches
`timescale 1ns/1ps
module pcl_host_model (
    input wire logic clk,
    output logic serial_clock,
    output logic serial_in_line,
    output logic latch_strobe
);
    import pcl_pkg::*;
    initial begin
        serial_clock = 1'b0;
        serial_in_line = 1'b0;
        latch_strobe = 1'b0;
    end
    // half of a 160 ns serial period is 20 clk cycles; clock idles low between words
    task automatic send(input logic [PCL_WORD_W-1:0] w);
        for (int i = PCL_WORD_W - 1; i >= 0; i--) begin
            @(posedge clk) serial_in_line <= w[i];
            repeat (20) @(posedge clk);
            serial_clock <= 1'b1;
            repeat (20) @(posedge clk);
            serial_clock <= 1'b0;
        end
        repeat (4) @(posedge clk);
        // released data line shows the inverse, never a stale bit
        serial_in_line <= ~w[0];
        latch_strobe <= 1'b1;
        repeat (8) @(posedge clk);
        latch_strobe <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
endmodule

/* File: testbench/pcl_latch_ctrl_tb.sv */
// self-checking bench of the pll control latch logic
`timescale 1ns/1ps
module pcl_latch_ctrl_tb;
    import pcl_pkg::*;
    typedef struct packed {
        logic [23:0] word;
        logic [2:0] cur;
        logic en;
        logic hold;
        logic pd;
        logic [2:0] mux;
        logic pol;
    } pcl_row_s;
    logic clk, reset_n, chip_enable, pump_event;
    logic serial_clock, serial_in_line, latch_strobe;
    logic [23:0] counter_word;
    logic ref_word_load, fb_word_load, counters_hold, timeout_hold, pump_output_en;
    logic [2:0] pump_current, outmux_select;
    logic pump_gain_bit, fastlock_active, detector_polarity_bit;
    logic detect_reset, ref_buffer_enable, powered_down;
    int error_cnt = 0;
    int tests_run = 0;
    int hold_cnt = 0;
    int ref_cnt = 0;
    int fb_cnt = 0;
    int base;
    int fb_base;
    pcl_row_s rows [5] = '{
        '{24'h0a80b2, 3'h5, 1'b1, 1'b0, 1'b0, 3'h3, 1'b1},
        '{24'h008102, 3'h1, 1'b0, 1'b0, 1'b0, 3'h0, 1'b0},
        '{24'h000006, 3'h0, 1'b0, 1'b1, 1'b0, 3'h0, 1'b0},
        '{24'h00000a, 3'h0, 1'b0, 1'b1, 1'b1, 3'h0, 1'b0},
        '{24'h038053, 3'h7, 1'b1, 1'b0, 1'b0, 3'h5, 1'b0}
    };

    pcl_latch_ctrl DUT (
        .clk(clk), .reset_n(reset_n), .serial_clock(serial_clock),
        .serial_in_line(serial_in_line), .latch_strobe(latch_strobe),
        .chip_enable(chip_enable), .pump_event(pump_event),
        .counter_word(counter_word), .ref_word_load(ref_word_load),
        .fb_word_load(fb_word_load), .counters_hold(counters_hold),
        .timeout_hold(timeout_hold), .pump_output_en(pump_output_en),
        .pump_current(pump_current), .pump_gain_bit(pump_gain_bit),
        .fastlock_active(fastlock_active), .detector_polarity_bit(detector_polarity_bit),
        .outmux_select(outmux_select), .detect_reset(detect_reset),
        .ref_buffer_enable(ref_buffer_enable), .powered_down(powered_down)
    );
    pcl_host_model host (
        .clk(clk), .serial_clock(serial_clock),
        .serial_in_line(serial_in_line), .latch_strobe(latch_strobe)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // cycles of forced timer load, so one-cycle pulses are counted exactly
    always @(posedge clk) begin
        if (timeout_hold === 1'b1) hold_cnt <= hold_cnt + 1;
        if (ref_word_load === 1'b1) ref_cnt <= ref_cnt + 1;
        if (fb_word_load === 1'b1) fb_cnt <= fb_cnt + 1;
    end

    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            pump_event <= 1'b1;
            @(posedge clk) pump_event <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask
    task automatic put(input logic [23:0] w);
        host.send(w);
        repeat (4) @(posedge clk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #200us;
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        reset_n = 1'b0;
        chip_enable = 1'b1;
        pump_event = 1'b0;
        repeat (5) @(posedge clk);
        check("reset_out", {18'h0, powered_down, pump_output_en, pump_gain_bit, pump_current},
              24'h000020);
        check("reset_word", counter_word, 24'h000000);
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        // bias settle time after enable
        repeat (260) @(posedge clk);
        foreach (rows[i]) begin
            put(rows[i].word);
            check("row", {14'h0, pump_current, pump_output_en, counters_hold, powered_down,
                  outmux_select, detector_polarity_bit}, {14'h0, rows[i][9:0]});
        end
        // initialization method: init, reference, feedback
        base = hold_cnt;
        put(24'h000003);
        check("init_pulse", 24'(hold_cnt - base), 24'h1);
        put(24'h123450);
        check("ref_word", counter_word, 24'h123450);
        base = hold_cnt;
        put(24'h011cd1);
        check("fb_pulse", 24'(hold_cnt - base), 24'h1);
        base = hold_cnt;
        put(24'h011cd5);
        check("fb_again", 24'(hold_cnt - base), 24'h0);
        check("fb_word", counter_word, 24'h011cd5);
        // synchronous power-down waits for a pump event
        put(24'h20000a);
        check("sync_wait", {23'h0, powered_down}, 24'h0);
        pulses(1);
        check("sync_pd", {22'h0, powered_down, pump_output_en}, 24'h2);
        put(24'h000002);
        check("pd_clear", {23'h0, powered_down}, 24'h0);
        put(24'h20000b);
        check("init_pd", {23'h0, powered_down}, 24'h1);
        put(24'h000002);
        put(24'h000001);
        // pin power-down, latch still written meanwhile
        chip_enable <= 1'b0;
        repeat (6) @(posedge clk);
        check("ce_low", {18'h0, powered_down, pump_output_en, ref_buffer_enable, detect_reset,
              timeout_hold, counters_hold}, 24'h000027);
        put(24'h000082);
        check("pd_write", {23'h0, detector_polarity_bit}, 24'h1);
        chip_enable <= 1'b1;
        repeat (260) @(posedge clk);
        check("ce_high", {22'h0, powered_down, detector_polarity_bit}, 24'h1);
        // fastlock mode two, timeout field 1: 7 comparison events
        put(24'h190e02);
        put(24'h200001);
        check("fl2_on", {19'h0, pump_gain_bit, fastlock_active, pump_current}, 24'h1e);
        pulses(6);
        check("fl2_hold", {23'h0, pump_gain_bit}, 24'h1);
        pulses(1);
        check("fl2_off", {19'h0, pump_gain_bit, fastlock_active, pump_current}, 24'h02);
        // mode one ignores the timer, host leaves fastlock
        put(24'h190a02);
        put(24'h200001);
        pulses(10);
        check("fl1_stay", {19'h0, pump_gain_bit, fastlock_active, pump_current}, 24'h1e);
        put(24'h000001);
        check("fl1_off", {21'h0, pump_current}, 24'h2);
        // enable bit clear: gain write gives no fastlock
        put(24'h190002);
        put(24'h200001);
        check("fl_off", {20'h0, fastlock_active, pump_current}, 24'h2);
        // counter reset method: hold, reference, feedback, release
        put(24'h000006);
        check("crst_hold", {22'h0, counters_hold, pump_output_en}, 24'h2);
        base = ref_cnt;
        fb_base = fb_cnt;
        put(24'h000010);
        put(24'h000021);
        check("ref_pulse", 24'(ref_cnt - base), 24'h1);
        check("fb_pulse_cnt", 24'(fb_cnt - fb_base), 24'h1);
        check("fb_word2", counter_word, 24'h000021);
        put(24'h000002);
        check("crst_off", {22'h0, counters_hold, pump_output_en}, 24'h1);
        tally_and_finish();
    end
endmodule
